// file: urx_pkg.sv
// Register map, field layouts and receiver constants for the serial receive status block
package urx_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_DATA     = 8'h04;
  localparam logic [7:0] OFS_CTRL     = 8'h08;
  localparam logic [7:0] OFS_BAUD     = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;

  // Status flags, bit 5 down to bit 0; same layout in interrupt status and mask
  typedef struct packed {
    logic rxfull;
    logic idle;
    logic ovr;
    logic noise;
    logic frame;
    logic parity;
  } urx_flags_s;

  // Control register, bit 3 down to bit 0
  typedef struct packed {
    logic idle_count_select;
    logic parity_odd;
    logic parity_enable;
    logic char9;
  } urx_ctrl_s;

  localparam urx_flags_s FLAGS_RST    = 6'h00;
  localparam urx_ctrl_s  CTRL_RST     = 4'h0;
  localparam logic [1:0] STATUS_PAD   = 2'h0;

  // 16x oversampling and sample windows
  localparam logic [3:0] OS_LAST          = 4'hF;
  localparam logic [3:0] START_SAMP_FIRST = 4'h5;
  localparam logic [3:0] START_SAMP_LAST  = 4'hB;
  localparam logic [3:0] BIT_SAMP_FIRST   = 4'h7;
  localparam logic [3:0] BIT_SAMP_LAST    = 4'h9;

  // Character geometry in bit times
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] CHAR_BITS_8 = 4'hA;
  localparam logic [3:0] CHAR_BITS_9 = 4'hB;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } urx_rx_e;

  typedef struct packed {
    logic        rx_meta;
    logic        rx_sync;
    logic [15:0] div_cnt;
    logic        tick;
    urx_rx_e     rx_state;
    logic [3:0]  os_cnt;
    logic [2:0]  n_one;
    logic [2:0]  n_samp;
    logic [3:0]  bit_idx;
    logic [8:0]  shift;
    logic        noise;
    logic        par;
    logic [3:0]  idle_cnt;
    logic        idle_allowed;
    logic [8:0]  rdata;
    urx_flags_s  flags;
    urx_flags_s  arm;
    urx_ctrl_s   ctrl;
    logic [15:0] baud_div;
    urx_flags_s  int_stat;
    urx_flags_s  int_mask;
    logic [31:0] prdata;
    logic        perr;
  } urx_state_s;

endpackage : urx_pkg

// file: urx_serial_rx_status.sv
// Serial receiver with status flags, two-step flag clearing and an APB register slave
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module urx_serial_rx_status
  import urx_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV_RST = 16'h0036
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             irq
);

  urx_state_s s_reg;
  urx_state_s s_next;

  logic       setup;
  logic       access;
  logic       status_rd;
  logic       data_rd;
  logic       rx_done;
  logic       stop_zero;
  logic       par_err;
  logic       noise_all;
  logic [8:0] char_data;
  logic [3:0] idle_thr;

  function automatic logic vote(input logic [2:0] ones, input logic [2:0] total);
    vote = ({ones, 1'b0} > {1'b0, total});
  endfunction : vote

  function automatic logic noisy(input logic [2:0] ones, input logic [2:0] total);
    noisy = (ones != 3'h0) && (ones != total);
  endfunction : noisy

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    sat_inc = (v == CHAR_BITS_9) ? v : v + 4'h1;
  endfunction : sat_inc

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_STATUS) || (a == OFS_DATA) || (a == OFS_CTRL) ||
             (a == OFS_BAUD) || (a == OFS_INT_STAT) || (a == OFS_INT_MASK);
  endfunction : mapped

  function automatic logic [31:0] read_mux(input urx_state_s st, input logic [7:0] a);
    read_mux = 32'h0000_0000;
    case (a)
      OFS_STATUS:   read_mux[7:0] = {STATUS_PAD, st.flags};
      OFS_DATA:     read_mux[8:0] = st.rdata;
      OFS_CTRL:     read_mux[3:0] = st.ctrl;
      OFS_BAUD:     read_mux[15:0] = st.baud_div;
      OFS_INT_STAT: read_mux[5:0] = st.int_stat;
      OFS_INT_MASK: read_mux[5:0] = st.int_mask;
      default:      read_mux = 32'h0000_0000;
    endcase
  endfunction : read_mux

  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign status_rd = access && !pwrite && (paddr == OFS_STATUS);
  assign data_rd   = access && !pwrite && (paddr == OFS_DATA);
  assign idle_thr  = s_reg.ctrl.char9 ? CHAR_BITS_9 : CHAR_BITS_8;

  always_comb begin
    logic       b;
    logic       nz;
    logic       in_win;
    logic       buf_free;
    logic [3:0] nbits;
    urx_flags_s clr;
    urx_flags_s ev;
    b         = 1'b0;
    nz        = 1'b0;
    in_win    = 1'b0;
    buf_free  = 1'b0;
    nbits     = s_reg.ctrl.char9 ? DATA_BITS_9 : DATA_BITS_8;
    clr       = FLAGS_RST;
    ev        = FLAGS_RST;
    rx_done   = 1'b0;
    stop_zero = 1'b0;
    par_err   = 1'b0;
    noise_all = 1'b0;
    char_data = s_reg.ctrl.char9 ? s_reg.shift : {1'b0, s_reg.shift[8:1]};
    s_next    = s_reg;

    // Pin passes two flops before anything looks at it
    s_next.rx_meta = rxd;
    s_next.rx_sync = s_reg.rx_meta;

    // Oversampling tick; a zero divisor behaves as one
    s_next.tick = 1'b0;
    if (s_reg.div_cnt + 16'h0001 >= s_reg.baud_div) begin
      s_next.div_cnt = 16'h0000;
      s_next.tick    = 1'b1;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 16'h0001;
    end

    // Receiver
    case (s_reg.rx_state)
      RX_IDLE: begin
        if (!s_reg.rx_sync) begin
          // Realign the bit clock to the falling edge
          s_next.rx_state = RX_START;
          s_next.div_cnt  = 16'h0000;
          s_next.os_cnt   = 4'h0;
          s_next.n_one    = 3'h0;
          s_next.n_samp   = 3'h0;
          s_next.bit_idx  = 4'h0;
          s_next.noise    = 1'b0;
          s_next.par      = 1'b0;
          s_next.idle_cnt = 4'h0;
        end else if (s_reg.tick) begin
          s_next.os_cnt = s_reg.os_cnt + 4'h1;
          if (s_reg.os_cnt == OS_LAST) begin
            s_next.idle_cnt = sat_inc(s_reg.idle_cnt);
          end
        end
      end
      RX_START, RX_DATA, RX_STOP: begin
        if (s_reg.tick) begin
          s_next.os_cnt = s_reg.os_cnt + 4'h1;
          if (s_reg.rx_state == RX_START) begin
            in_win = (s_reg.os_cnt >= START_SAMP_FIRST) && (s_reg.os_cnt <= START_SAMP_LAST);
          end else begin
            in_win = (s_reg.os_cnt >= BIT_SAMP_FIRST) && (s_reg.os_cnt <= BIT_SAMP_LAST);
          end
          if (in_win) begin
            s_next.n_one  = s_reg.n_one + {2'h0, s_reg.rx_sync};
            s_next.n_samp = s_reg.n_samp + 3'h1;
          end
          if (s_reg.os_cnt == OS_LAST) begin
            b              = vote(s_reg.n_one, s_reg.n_samp);
            nz             = noisy(s_reg.n_one, s_reg.n_samp);
            s_next.n_one   = 3'h0;
            s_next.n_samp  = 3'h0;
            if (s_reg.rx_state != RX_START) begin
              // Mode 0 counts high bits inside the frame, mode 1 waits for the stop bit
              if (!s_reg.ctrl.idle_count_select && b) begin
                s_next.idle_cnt = sat_inc(s_reg.idle_cnt);
              end else begin
                s_next.idle_cnt = 4'h0;
              end
            end
            case (s_reg.rx_state)
              RX_START: begin
                s_next.rx_state = b ? RX_IDLE : RX_DATA;
                s_next.noise    = nz;
              end
              RX_DATA: begin
                s_next.shift   = {b, s_reg.shift[8:1]};
                s_next.par     = s_reg.par ^ b;
                s_next.noise   = s_reg.noise | nz;
                s_next.bit_idx = s_reg.bit_idx + 4'h1;
                if (s_reg.bit_idx + 4'h1 == nbits) begin
                  s_next.rx_state = RX_STOP;
                end
              end
              default: begin
                s_next.rx_state = RX_IDLE;
                rx_done         = 1'b1;
                stop_zero       = !b;
                noise_all       = s_reg.noise | nz;
                par_err         = s_reg.ctrl.parity_enable && (s_reg.par != s_reg.ctrl.parity_odd);
              end
            endcase
          end
        end
      end
      default: s_next.rx_state = RX_IDLE;
    endcase

    // Data read clears whatever the preceding status read armed
    if (data_rd) begin
      clr = s_reg.arm;
    end
    s_next.flags = s_reg.flags & ~clr;
    buf_free     = !s_reg.flags.rxfull || clr.rxfull;

    // New character; a clear in the same cycle frees the buffer, the set wins
    if (rx_done) begin
      if (buf_free) begin
        s_next.rdata        = char_data;
        s_next.flags.rxfull = 1'b1;
        s_next.flags.noise  = s_next.flags.noise | noise_all;
        s_next.flags.frame  = s_next.flags.frame | stop_zero;
        s_next.flags.parity = s_next.flags.parity | par_err;
        s_next.idle_allowed = 1'b1;
        ev.rxfull           = 1'b1;
        ev.noise            = noise_all;
        ev.frame            = stop_zero;
        ev.parity           = par_err;
      end else begin
        s_next.flags.ovr = 1'b1;
        ev.ovr           = 1'b1;
      end
    end

    // One idle report per received character
    if (s_reg.idle_allowed && (s_reg.idle_cnt >= idle_thr)) begin
      s_next.flags.idle   = 1'b1;
      s_next.idle_allowed = 1'b0;
      ev.idle             = 1'b1;
    end

    // Arm from the value software actually saw; noise and parity arm unconditionally
    if (status_rd) begin
      s_next.arm.rxfull = s_reg.prdata[5];
      s_next.arm.idle   = s_reg.prdata[4];
      s_next.arm.ovr    = s_reg.prdata[3];
      s_next.arm.noise  = 1'b1;
      s_next.arm.frame  = s_reg.prdata[1];
      s_next.arm.parity = 1'b1;
    end else if (data_rd) begin
      s_next.arm = FLAGS_RST;
    end

    // APB: read data is captured in setup so prdata comes from a flop
    if (setup) begin
      s_next.prdata = pwrite ? 32'h0000_0000 : read_mux(s_reg, paddr);
      s_next.perr   = !mapped(paddr);
    end

    // Status and data registers ignore writes
    s_next.int_stat = s_reg.int_stat | ev;
    if (access && pwrite) begin
      case (paddr)
        OFS_CTRL:     s_next.ctrl     = pwdata[3:0];
        OFS_BAUD:     s_next.baud_div = pwdata[15:0];
        OFS_INT_STAT: s_next.int_stat = (s_reg.int_stat & ~pwdata[5:0]) | ev;
        OFS_INT_MASK: s_next.int_mask = pwdata[5:0];
        default:      s_next.int_mask = s_reg.int_mask;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg              <= '0;
      s_reg.rx_meta      <= 1'b1;
      s_reg.rx_sync      <= 1'b1;
      s_reg.rx_state     <= RX_IDLE;
      s_reg.flags        <= FLAGS_RST;
      s_reg.arm          <= FLAGS_RST;
      s_reg.ctrl         <= CTRL_RST;
      s_reg.baud_div     <= BAUD_DIV_RST;
      s_reg.int_stat     <= FLAGS_RST;
      s_reg.int_mask     <= FLAGS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata  = s_reg.prdata;
  assign pready  = 1'b1;
  assign pslverr = s_reg.perr;
  assign irq     = |(s_reg.int_stat & s_reg.int_mask);

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_status_seen_full;
    status_rd && s_reg.prdata[5];
  endsequence

  sequence s_status_any;
    status_rd;
  endsequence

  sequence s_data_clean;
    data_rd && !rx_done;
  endsequence

  sequence s_status_seen_idle;
    status_rd && s_reg.prdata[4];
  endsequence

  sequence s_status_seen_ovr;
    status_rd && s_reg.prdata[3];
  endsequence

  sequence s_status_seen_frame;
    status_rd && s_reg.prdata[1];
  endsequence

  a_full_on_load: assert property (rx_done && !s_reg.flags.rxfull |=>
      s_reg.flags.rxfull && (s_reg.rdata == $past(char_data)))
    else $error("receive-full or data not loaded");

  a_full_clear_seq: assert property (s_status_seen_full ##[2:3] s_data_clean |=> !s_reg.flags.rxfull)
    else $error("receive-full not cleared by read sequence");

  a_idle_thresh: assert property ($rose(s_reg.flags.idle) |->
      ($past(s_reg.idle_cnt) >= $past(idle_thr)) && $past(s_reg.idle_allowed))
    else $error("idle set before a full character time");

  a_idle_once: assert property ($fell(s_reg.idle_allowed) |->
      !s_reg.idle_allowed [*2])
    else $error("idle rearmed without a character");

  a_overrun_keep: assert property (rx_done && s_reg.flags.rxfull && !data_rd |=>
      s_reg.flags.ovr && $stable(s_reg.rdata))
    else $error("overrun not flagged or buffer overwritten");

  a_noise_clear_seq: assert property (s_status_any ##[2:3] s_data_clean |=> !s_reg.flags.noise)
    else $error("noise not cleared by read sequence");

  a_noise_with_full: assert property ($rose(s_reg.flags.noise) |-> s_reg.flags.rxfull && $past(rx_done))
    else $error("noise set without a received character");

  a_frame_on_stop: assert property (rx_done && !s_reg.flags.rxfull && stop_zero |=>
      s_reg.flags.frame && s_reg.flags.rxfull)
    else $error("framing error missed");

  a_parity_set: assert property ($rose(s_reg.flags.parity) |->
      $past(rx_done) && $past(s_reg.ctrl.parity_enable))
    else $error("parity error without parity enabled");

  a_flags_read_only: assert property ($fell(s_reg.flags.frame) || $fell(s_reg.flags.ovr) |->
      $past(data_rd))
    else $error("flag cleared other than by data read");

  a_idle_clear_seq: assert property (s_status_seen_idle ##[2:3] s_data_clean |=> !s_reg.flags.idle)
    else $error("idle not cleared by read sequence");

  a_ovr_clear_seq: assert property (s_status_seen_ovr ##[2:3] s_data_clean |=> !s_reg.flags.ovr)
    else $error("overrun not cleared by read sequence");

  a_frame_clear_seq: assert property (s_status_seen_frame ##[2:3] s_data_clean |=> !s_reg.flags.frame)
    else $error("framing error not cleared by read sequence");

  a_parity_clear_seq: assert property (s_status_any ##[2:3] s_data_clean |=> !s_reg.flags.parity)
    else $error("parity error not cleared by read sequence");

  a_idle_after_stop: assert property ($rose(s_reg.flags.idle) && s_reg.ctrl.idle_count_select |->
      $past(s_reg.rx_state) == RX_IDLE)
    else $error("idle counted inside a frame in stop-bit mode");

  a_reset_flags_clear: assert property ($rose(presetn) |->
      (s_reg.flags == FLAGS_RST) && (s_reg.arm == FLAGS_RST))
    else $error("flags or clear arms not cleared by reset");

endmodule : urx_serial_rx_status

`default_nettype wire

// file: urx_serial_rx_status_tb_top.sv
// Self-checking bench for the serial receive status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end

module urx_serial_rx_status_tb_top;
  import urx_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        pready;
  logic        pslverr;
  logic        serr;
  logic        rxd;
  logic        irq;
  int          mismatches = 0;
  int          compares = 0;

  always #5 pclk = ~pclk;

  urx_serial_rx_status #(.BAUD_DIV_RST(16'h0001)) i_urx_serial_rx_status (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .irq(irq));

  urx_tx_model i_urx_tx_model (.clk(pclk), .rxd(rxd));

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Status polling arms the clear sequence, as software would
  task automatic poll(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while ((rdat[7:0] & m) == 8'h00 && n < 400);
    if (n >= 400) begin
      mismatches++;
      summarize();
    end
  endtask : poll

  // Lets any pending idle report land before flushing flags
  task automatic clr();
    repeat (220) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    apb(1'b1, OFS_INT_STAT, 32'h3F);
  endtask : clr

  task automatic t_reset();
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, rdat)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, rdat)
    apb(1'b0, OFS_BAUD, 32'h0);
    `CHK("baud", 32'h1, rdat)
    apb(1'b0, OFS_INT_MASK, 32'h0);
    `CHK("mask", 32'h0, rdat)
    `CHK("irq", 1'b0, irq)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped err", 1'b1, serr)
    `CHK("unmapped data", 32'h0, rdat)
    $display("test reset done");
  endtask : t_reset

  task automatic t_basic();
    i_urx_tx_model.send(9'h0A5, 1'b0, 1'b1, 1'b0);
    poll(8'h20);
    `CHK("status full", 32'h20, rdat)
    apb(1'b1, OFS_STATUS, 32'hFF);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status after write", 32'h20, rdat)
    apb(1'b0, OFS_DATA, 32'h0);
    `CHK("data", 32'hA5, rdat)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status cleared", 32'h0, rdat)
    clr();
    $display("test basic done");
  endtask : t_basic

  task automatic t_flag(input string nm, input logic [8:0] d, input logic stop, input logic gl,
                        input logic [31:0] ctl, input logic [31:0] exp);
    apb(1'b1, OFS_CTRL, ctl);
    i_urx_tx_model.send(d, ctl[0], stop, gl);
    poll(8'h20);
    `CHK(nm, exp, rdat)
    apb(1'b0, OFS_DATA, 32'h0);
    `CHK("data", {23'h0, d}, rdat)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("flags cleared", 32'h0, rdat)
    clr();
    $display("test %s done", nm);
  endtask : t_flag

  task automatic t_overrun();
    apb(1'b1, OFS_CTRL, 32'h0);
    i_urx_tx_model.send(9'h011, 1'b0, 1'b1, 1'b0);
    // Second frame carries a framing error that must be lost with it
    i_urx_tx_model.send(9'h022, 1'b0, 1'b0, 1'b0);
    poll(8'h08);
    `CHK("overrun status", 32'h28, rdat)
    apb(1'b0, OFS_DATA, 32'h0);
    `CHK("kept data", 32'h11, rdat)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("overrun cleared", 32'h0, rdat)
    clr();
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_idle0();
    apb(1'b1, OFS_CTRL, 32'h0);
    i_urx_tx_model.send(9'h0FF, 1'b0, 1'b1, 1'b0);
    repeat (80) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("idle early", 32'h30, rdat)
    apb(1'b0, OFS_DATA, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("idle cleared", 32'h0, rdat)
    repeat (400) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("idle once", 32'h0, rdat)
    clr();
    $display("test idle count 0 done");
  endtask : t_idle0

  task automatic t_idle1(input logic [31:0] ctl, input logic [8:0] d, input int early);
    apb(1'b1, OFS_CTRL, ctl);
    i_urx_tx_model.send(d, ctl[0], 1'b1, 1'b0);
    repeat (early) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("no idle yet", 32'h20, rdat)
    repeat (30) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("idle set", 32'h30, rdat)
    clr();
    $display("test idle count 1 done");
  endtask : t_idle1

  task automatic t_irq();
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_INT_MASK, 32'h20);
    i_urx_tx_model.send(9'h05A, 1'b0, 1'b1, 1'b0);
    poll(8'h20);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b0, OFS_INT_STAT, 32'h0);
    `CHK("int status", 32'h20, rdat)
    apb(1'b1, OFS_INT_MASK, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, OFS_INT_MASK, 32'h20);
    `CHK("irq unmasked", 1'b1, irq)
    apb(1'b1, OFS_INT_STAT, 32'h20);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b1, OFS_INT_MASK, 32'h0);
    clr();
    $display("test irq done");
  endtask : t_irq

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_basic();
    t_flag("noise", 9'h03C, 1'b1, 1'b1, 32'h0, 32'h24);
    t_flag("framing", 9'h03C, 1'b0, 1'b0, 32'h0, 32'h22);
    t_flag("parity even", 9'h001, 1'b1, 1'b0, 32'h2, 32'h21);
    t_flag("parity good", 9'h003, 1'b1, 1'b0, 32'h2, 32'h20);
    t_flag("parity odd", 9'h003, 1'b1, 1'b0, 32'h6, 32'h21);
    t_flag("nine bit", 9'h1A5, 1'b1, 1'b0, 32'h1, 32'h20);
    t_overrun();
    t_idle0();
    t_idle1(32'h8, 9'h0FF, 150);
    t_idle1(32'h9, 9'h1FF, 166);
    t_irq();
    summarize();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    summarize();
  end
endmodule : urx_serial_rx_status_tb_top
`default_nettype wire

// file: urx_tx_model.sv
// Behavioural remote serial transmitter driving the receive line
`timescale 1ns/100ps
`default_nettype none

module urx_tx_model (
  input  wire logic clk,
  output var logic  rxd
);
  initial rxd = 1'b1;

  // Sixteen clocks per bit, matching a baud divisor of one
  task automatic send(input logic [8:0] d, input logic nine, input logic stop, input logic glitch);
    int i;
    rxd <= 1'b0;
    repeat (8) @(posedge clk);
    // One-cycle spike inside the start-bit sample window
    rxd <= glitch;
    @(posedge clk);
    rxd <= 1'b0;
    repeat (7) @(posedge clk);
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      rxd <= d[i];
      repeat (16) @(posedge clk);
    end
    rxd <= stop;
    repeat (16) @(posedge clk);
    // Back to idle high, so a following frame still sees a falling edge
    rxd <= 1'b1;
    @(posedge clk);
  endtask : send
endmodule : urx_tx_model
`default_nettype wire
